//--- logic/rld_decode.sv
// i/o decode and access lock gate for the configuration register file
`timescale 1ns/100ps
`default_nettype none
module rld_decode #(
    parameter int ADDR_W = rld_pkg::ADDR_W,
    parameter int DATA_W = rld_pkg::DATA_W
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic [ADDR_W-1:0]       io_addr,
    input  wire logic [DATA_W-1:0]       io_wdata,
    input  wire logic [1:0]              io_be,
    input  wire logic                    io_rd_stb,
    input  wire logic                    io_wr_stb,
    input  wire logic [3:0]              dma1_mask,
    input  wire logic [3:0]              dma2_mask,
    input  wire logic [7:0]              pport_ctl,
    output var  logic                    io_done_r,
    output var  logic                    io_claim_r,
    output var  logic                    at_fwd_r,
    output var  logic [DATA_W-1:0]       rdata_r,
    output var  logic                    status_rd_r,
    output var  logic                    reg_rd_r,
    output var  logic                    reg_wr_r,
    output var  logic [rld_pkg::IDX_W-1:0] reg_idx_r,
    output var  logic [DATA_W-1:0]       reg_wdata_r,
    output var  logic [1:0]              reg_be_r,
    output var  logic                    legacy_rd_r,
    output var  logic                    legacy_wr_r,
    output var  rld_pkg::rld_legacy_type legacy_sel_r,
    output var  logic                    unlocked_r
);
    // ---------------------------------------------------------------
    // decode functions
    // ---------------------------------------------------------------
    function automatic logic in_range(
        input logic [rld_pkg::LEG_W-1:0] a,
        input logic [rld_pkg::LEG_W-1:0] lo,
        input logic [rld_pkg::LEG_W-1:0] hi
    );
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // ten-bit decode of the legacy ports
    function automatic rld_pkg::rld_legacy_type legacy_decode(
        input logic [rld_pkg::LEG_W-1:0] a
    );
        legacy_decode = rld_pkg::RLD_SEL_NONE;
        if (in_range(a, rld_pkg::DMA1_LO, rld_pkg::DMA1_HI)) begin
            legacy_decode = rld_pkg::RLD_SEL_DMA1;
        end else if (in_range(a, rld_pkg::PIC1_LO, rld_pkg::PIC1_HI)) begin
            legacy_decode = rld_pkg::RLD_SEL_PIC1;
        end else if (in_range(a, rld_pkg::TIMER_LO, rld_pkg::TIMER_HI)) begin
            legacy_decode = rld_pkg::RLD_SEL_TIMER;
        end else if (in_range(a, rld_pkg::KBD_LO, rld_pkg::KBD_HI)) begin
            legacy_decode = a[0] ? rld_pkg::RLD_SEL_PORTB : rld_pkg::RLD_SEL_KBD;
        end else if (in_range(a, rld_pkg::RTC_LO, rld_pkg::RTC_HI)) begin
            legacy_decode = a[0] ? rld_pkg::RLD_SEL_RTCD : rld_pkg::RLD_SEL_RTCA;
        end else if (a == rld_pkg::A20_PORT) begin
            legacy_decode = rld_pkg::RLD_SEL_A20;
        end else if (in_range(a, rld_pkg::PAGE_LO, rld_pkg::PAGE_HI)) begin
            legacy_decode = rld_pkg::RLD_SEL_PAGE;
        end else if (in_range(a, rld_pkg::PIC2_LO, rld_pkg::PIC2_HI)) begin
            legacy_decode = rld_pkg::RLD_SEL_PIC2;
        end else if (in_range(a, rld_pkg::DMA2_LO, rld_pkg::DMA2_HI)) begin
            legacy_decode = rld_pkg::RLD_SEL_DMA2;
        end
    endfunction

    // ports that stay open while locked
    function automatic logic always_open(
        input logic [rld_pkg::IDX_W-1:0] idx
    );
        always_open = (idx == rld_pkg::IDX_EMS_PTR)
                   || (idx == rld_pkg::IDX_RTC_SHADOW)
                   || (idx == rld_pkg::IDX_EMS_PAGE);
    endfunction

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    rld_pkg::rld_lock_type   lock_r;
    rld_pkg::rld_lock_type   lock_nxt;
    rld_pkg::rld_legacy_type leg_sel;
    rld_pkg::rld_legacy_type leg_sel_nxt;

    logic                        acc;
    logic                        is_wr;
    logic                        is_rd;
    logic [rld_pkg::LEG_W-1:0]   addr_lo;
    logic [rld_pkg::IDX_W-1:0]   addr_idx;
    logic                        hit_lock;
    logic                        hit_status;
    logic                        hit_xx72;
    logic                        hit_cpclr;
    logic                        hit_cprst;
    logic                        hit_full;
    logic                        hit_legacy;
    logic                        is_open;
    logic                        unlocked;
    logic                        key_wr;
    logic                        key_ok;
    logic                        reg_ok;
    logic                        status_ok;
    logic                        lock_ok;
    logic                        legacy_ok;
    logic                        claim;
    logic                        status_read;
    logic                        toggle_q;
    logic [DATA_W-1:0]           status_word;

    logic                        io_done_nxt;
    logic                        io_claim_nxt;
    logic                        at_fwd_nxt;
    logic [DATA_W-1:0]           rdata_nxt;
    logic                        status_rd_nxt;
    logic                        reg_rd_nxt;
    logic                        reg_wr_nxt;
    logic [rld_pkg::IDX_W-1:0]   reg_idx_nxt;
    logic [DATA_W-1:0]           reg_wdata_nxt;
    logic [1:0]                  reg_be_nxt;
    logic                        legacy_rd_nxt;
    logic                        legacy_wr_nxt;

    // ---------------------------------------------------------------
    // cycle qualification
    // ---------------------------------------------------------------
    // a write strobe wins when both arrive together
    assign is_wr = io_wr_stb;
    assign is_rd = io_rd_stb & ~io_wr_stb;
    assign acc   = is_wr | is_rd;

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    assign addr_lo  = io_addr[rld_pkg::LEG_W-1:0];
    assign addr_idx = io_addr[ADDR_W-1:rld_pkg::IDX_LSB];

    assign hit_lock   = (io_addr == rld_pkg::LOCK_PORT);
    assign hit_status = (io_addr == rld_pkg::STATUS_PORT);
    assign hit_cpclr  = (io_addr == rld_pkg::COPRO_CLR);
    assign hit_cprst  = (io_addr == rld_pkg::COPRO_RST);

    // every xx72 port from 1072 upward except the status port fc72, all bits compared
    assign hit_xx72 = (addr_lo == rld_pkg::REG_LOW_FIELD)
                   && (addr_idx >= rld_pkg::IDX_FIRST)
                   && !hit_status;

    assign hit_full = hit_lock | hit_status | hit_xx72
                    | hit_cpclr | hit_cprst;

    // upper six bits ignored for three-digit ports
    assign leg_sel    = legacy_decode(addr_lo);
    assign hit_legacy = !hit_full && (leg_sel != rld_pkg::RLD_SEL_NONE);

    assign leg_sel_nxt = hit_cpclr  ? rld_pkg::RLD_SEL_CPCLR :
                         hit_cprst  ? rld_pkg::RLD_SEL_CPRST :
                         hit_legacy ? leg_sel : rld_pkg::RLD_SEL_NONE;

    // ---------------------------------------------------------------
    // lock gate
    // ---------------------------------------------------------------
    assign unlocked = (lock_r == rld_pkg::RLD_UNLOCKED);
    assign is_open  = always_open(addr_idx);

    // protected ports answer only while unlocked
    assign reg_ok    = hit_xx72 && (is_open || unlocked);
    assign status_ok = hit_status && unlocked;

    // the lock port takes writes only; reads go out
    assign lock_ok   = hit_lock && is_wr;
    assign legacy_ok = hit_legacy || hit_cpclr || hit_cprst;

    assign claim = acc && (reg_ok || status_ok || lock_ok || legacy_ok);

    // ---------------------------------------------------------------
    // key evaluation
    // ---------------------------------------------------------------
    // only the low byte carries the key
    assign key_wr = lock_ok && io_be[0];
    assign key_ok = (io_wdata[7:0] == rld_pkg::UNLOCK_KEY);

    always_comb begin
        lock_nxt = lock_r;
        if (key_wr) begin
            unique case (key_ok)
                1'b1: begin
                    lock_nxt = rld_pkg::RLD_UNLOCKED;
                end
                1'b0: begin
                    lock_nxt = rld_pkg::RLD_LOCKED;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // status word
    // ---------------------------------------------------------------
    // every read of the port flips the toggle, claimed or not
    assign status_read = is_rd && hit_status;

    rld_toggle_bit u_toggle (
        .clk  (clk),
        .rst  (rst),
        .flip (status_read),
        .q_r  (toggle_q)
    );

    always_comb begin
        status_word = rld_pkg::ST_UNUSED_VAL;
        status_word[rld_pkg::ST_TOGGLE_BIT] = toggle_q;
        status_word[rld_pkg::ST_DMA2_LSB +: 4] = dma2_mask;
        status_word[rld_pkg::ST_DMA1_LSB +: 4] = dma1_mask;
        status_word[rld_pkg::ST_PDIR_BIT] = pport_ctl[rld_pkg::PCTL_DIR_BIT];
    end

    // ---------------------------------------------------------------
    // next values of the answer
    // ---------------------------------------------------------------
    assign io_done_nxt  = acc;
    assign io_claim_nxt = claim;
    assign at_fwd_nxt   = acc && !claim;

    // a write to the status port is claimed only while unlocked and stores nothing
    assign status_rd_nxt = is_rd && status_ok;
    assign rdata_nxt     = status_rd_nxt ? status_word : rdata_r;

    assign reg_rd_nxt    = is_rd && reg_ok;
    assign reg_wr_nxt    = is_wr && reg_ok;
    assign reg_idx_nxt   = reg_ok ? addr_idx : reg_idx_r;
    assign reg_wdata_nxt = reg_wr_nxt ? io_wdata : reg_wdata_r;
    assign reg_be_nxt    = reg_ok ? io_be : reg_be_r;

    assign legacy_rd_nxt = is_rd && legacy_ok;
    assign legacy_wr_nxt = is_wr && legacy_ok;

    // ---------------------------------------------------------------
    // lock state register
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            lock_r <= rld_pkg::RLD_LOCKED;
        end else begin
            lock_r <= lock_nxt;
        end
    end

    // ---------------------------------------------------------------
    // cycle strobes
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            io_done_r   <= 1'b0;
            io_claim_r  <= 1'b0;
            at_fwd_r    <= 1'b0;
            status_rd_r <= 1'b0;
            reg_rd_r    <= 1'b0;
            reg_wr_r    <= 1'b0;
            legacy_rd_r <= 1'b0;
            legacy_wr_r <= 1'b0;
        end else begin
            io_done_r   <= io_done_nxt;
            io_claim_r  <= io_claim_nxt;
            at_fwd_r    <= at_fwd_nxt;
            status_rd_r <= status_rd_nxt;
            reg_rd_r    <= reg_rd_nxt;
            reg_wr_r    <= reg_wr_nxt;
            legacy_rd_r <= legacy_rd_nxt;
            legacy_wr_r <= legacy_wr_nxt;
        end
    end

    // ---------------------------------------------------------------
    // data and selects
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r      <= rld_pkg::RDATA_RST;
            reg_idx_r    <= '0;
            reg_wdata_r  <= '0;
            reg_be_r     <= '0;
            legacy_sel_r <= rld_pkg::RLD_SEL_NONE;
            unlocked_r   <= 1'b0;
        end else begin
            rdata_r      <= rdata_nxt;
            reg_idx_r    <= reg_idx_nxt;
            reg_wdata_r  <= reg_wdata_nxt;
            reg_be_r     <= reg_be_nxt;
            legacy_sel_r <= acc ? leg_sel_nxt : legacy_sel_r;
            unlocked_r   <= (lock_nxt == rld_pkg::RLD_UNLOCKED);
        end
    end
endmodule
`default_nettype wire

//--- include/rld_pkg.sv
// constants and types for the register lock and i/o decode block
`default_nettype none
package rld_pkg;
    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int ADDR_W  = 16;
    localparam int DATA_W  = 16;
    localparam int LEG_W   = 10;
    localparam int IDX_W   = 6;
    localparam int IDX_LSB = 10;
    localparam int SEL_W   = 4;

    // ---------------------------------------------------------------
    // full-width ports
    // ---------------------------------------------------------------
    localparam logic [15:0] LOCK_PORT   = 16'hf073;
    localparam logic [15:0] STATUS_PORT = 16'hfc72;
    localparam logic [15:0] COPRO_CLR   = 16'h00f0;
    localparam logic [15:0] COPRO_RST   = 16'h00f1;

    // ---------------------------------------------------------------
    // protected register window, ports xx72
    // ---------------------------------------------------------------
    localparam logic [9:0] REG_LOW_FIELD  = 10'h072;
    localparam logic [5:0] IDX_FIRST      = 6'h04;
    localparam logic [5:0] IDX_EMS_PTR    = 6'h38;
    localparam logic [5:0] IDX_RTC_SHADOW = 6'h39;
    localparam logic [5:0] IDX_EMS_PAGE   = 6'h3a;

    // ---------------------------------------------------------------
    // key and status layout
    // ---------------------------------------------------------------
    localparam logic [7:0]  UNLOCK_KEY     = 8'hda;
    localparam int          ST_TOGGLE_BIT  = 15;
    localparam int          ST_DMA2_LSB    = 8;
    localparam int          ST_DMA1_LSB    = 4;
    localparam int          ST_PDIR_BIT    = 3;
    localparam int          PCTL_DIR_BIT   = 5;
    localparam logic [15:0] ST_UNUSED_VAL  = 16'h0000;
    localparam logic [15:0] RDATA_RST      = 16'h0000;
    localparam logic        TOGGLE_RST     = 1'b0;

    // ---------------------------------------------------------------
    // legacy ten-bit port ranges
    // ---------------------------------------------------------------
    localparam logic [9:0] DMA1_LO   = 10'h000;
    localparam logic [9:0] DMA1_HI   = 10'h00f;
    localparam logic [9:0] PIC1_LO   = 10'h020;
    localparam logic [9:0] PIC1_HI   = 10'h021;
    localparam logic [9:0] TIMER_LO  = 10'h040;
    localparam logic [9:0] TIMER_HI  = 10'h043;
    localparam logic [9:0] KBD_LO    = 10'h060;
    localparam logic [9:0] KBD_HI    = 10'h06f;
    localparam logic [9:0] RTC_LO    = 10'h070;
    localparam logic [9:0] RTC_HI    = 10'h07f;
    localparam logic [9:0] PAGE_LO   = 10'h080;
    localparam logic [9:0] PAGE_HI   = 10'h09f;
    localparam logic [9:0] A20_PORT  = 10'h092;
    localparam logic [9:0] PIC2_LO   = 10'h0a0;
    localparam logic [9:0] PIC2_HI   = 10'h0a1;
    localparam logic [9:0] DMA2_LO   = 10'h0c0;
    localparam logic [9:0] DMA2_HI   = 10'h0df;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic {
        RLD_LOCKED   = 1'b0,
        RLD_UNLOCKED = 1'b1
    } rld_lock_type;

    typedef enum logic [3:0] {
        RLD_SEL_NONE   = 4'h0,
        RLD_SEL_DMA1   = 4'h1,
        RLD_SEL_PIC1   = 4'h2,
        RLD_SEL_TIMER  = 4'h3,
        RLD_SEL_KBD    = 4'h4,
        RLD_SEL_PORTB  = 4'h5,
        RLD_SEL_RTCA   = 4'h6,
        RLD_SEL_RTCD   = 4'h7,
        RLD_SEL_PAGE   = 4'h8,
        RLD_SEL_A20    = 4'h9,
        RLD_SEL_PIC2   = 4'ha,
        RLD_SEL_DMA2   = 4'hb,
        RLD_SEL_CPCLR  = 4'hc,
        RLD_SEL_CPRST  = 4'hd
    } rld_legacy_type;
endpackage
`default_nettype wire

//--- logic/rld_toggle_bit.sv
// status toggle flip-flop that inverts on each read
`timescale 1ns/100ps
`default_nettype none
module rld_toggle_bit (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic flip,
    output var  logic q_r
);
    logic q_nxt;

    // ---------------------------------------------------------------
    // toggle
    // ---------------------------------------------------------------
    assign q_nxt = flip ? ~q_r : q_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            q_r <= rld_pkg::TOGGLE_RST;
        end else begin
            q_r <= q_nxt;
        end
    end
endmodule
`default_nettype wire

//--- verif/rld_decode_props.sv
// assertion checker for the register lock and i/o decode block
`timescale 1ns/100ps
`default_nettype none
module rld_decode_props (
    input wire logic                    clk,
    input wire logic                    rst,
    input wire logic [15:0]             io_addr,
    input wire logic [15:0]             io_wdata,
    input wire logic [1:0]              io_be,
    input wire logic                    io_rd_stb,
    input wire logic                    io_wr_stb,
    input wire logic [3:0]              dma1_mask,
    input wire logic [3:0]              dma2_mask,
    input wire logic [7:0]              pport_ctl,
    input wire logic                    io_done_r,
    input wire logic                    io_claim_r,
    input wire logic                    at_fwd_r,
    input wire logic [15:0]             rdata_r,
    input wire logic                    status_rd_r,
    input wire logic                    legacy_rd_r,
    input wire rld_pkg::rld_legacy_type legacy_sel_r,
    input wire logic                    unlocked_r
);
    logic       any_stb;
    logic       rd_only;
    logic       key_wr;
    logic       prot_hit;
    logic [8:0] mirror_now;
    logic       par_r;
    assign any_stb    = io_rd_stb | io_wr_stb;
    assign rd_only    = io_rd_stb & ~io_wr_stb;
    assign key_wr     = io_wr_stb && io_addr == 16'hf073 && io_be[0];
    assign prot_hit   = io_addr[9:0] == 10'h072 && io_addr[15:10] >= 6'h04
                        && !(io_addr[15:10] inside {6'h38, 6'h39, 6'h3a});
    assign mirror_now = {dma2_mask, dma1_mask, pport_ctl[5]};
    // parity of status port reads since reset
    always_ff @(posedge clk) begin
        if (rst) begin
            par_r <= 1'b0;
        end else if (rd_only && io_addr == 16'hfc72) begin
            par_r <= ~par_r;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_answer; any_stb |=> io_done_r && (io_claim_r ^ at_fwd_r); endproperty
    a_answer: assert property (p_answer)
        else $error("cycle not answered once");
    property p_unlock; key_wr && io_wdata[7:0] == 8'hda |=> unlocked_r && io_claim_r; endproperty
    a_unlock: assert property (p_unlock)
        else $error("key did not unlock");
    property p_relock; key_wr && io_wdata[7:0] != 8'hda |=> !unlocked_r; endproperty
    a_relock: assert property (p_relock)
        else $error("other value did not lock");
    property p_locked; any_stb && prot_hit && !unlocked_r |=> at_fwd_r; endproperty
    a_locked: assert property (p_locked)
        else $error("locked access not forwarded");
    property p_open; any_stb && prot_hit && unlocked_r |=> io_claim_r; endproperty
    a_open: assert property (p_open)
        else $error("unlocked access not claimed");
    property p_toggle; status_rd_r |-> rdata_r[15] == !par_r; endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle bit wrong");
    property p_mirror; status_rd_r |-> rdata_r[14:0] == {3'h0, $past(mirror_now), 3'h0}; endproperty
    a_mirror: assert property (p_mirror)
        else $error("status mirror wrong");
    property p_status_wr; io_wr_stb && io_addr == 16'hfc72 |=> $stable(unlocked_r); endproperty
    a_status_wr: assert property (p_status_wr)
        else $error("status write changed state");
    property p_lock_rd; rd_only && io_addr == 16'hf073 |=> at_fwd_r && $stable(unlocked_r); endproperty
    a_lock_rd: assert property (p_lock_rd)
        else $error("lock port read claimed");
    property p_legacy;
        rd_only && io_addr[9:0] == 10'h061 |=> legacy_rd_r && legacy_sel_r == rld_pkg::RLD_SEL_PORTB;
    endproperty
    a_legacy: assert property (p_legacy)
        else $error("legacy alias not decoded");
    property p_full; any_stb && io_addr[9:0] == 10'h0f0 && io_addr[15:10] != 6'h00 |=> at_fwd_r; endproperty
    a_full: assert property (p_full)
        else $error("partial decode of full port");
    property p_reset; disable iff (1'b0) rst |=> !unlocked_r && !io_done_r; endproperty
    a_reset: assert property (p_reset)
        else $error("not locked after reset");
endmodule
bind rld_decode rld_decode_props u_rld_decode_props (
    .clk(clk), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata), .io_be(io_be),
    .io_rd_stb(io_rd_stb), .io_wr_stb(io_wr_stb), .dma1_mask(dma1_mask),
    .dma2_mask(dma2_mask), .pport_ctl(pport_ctl), .io_done_r(io_done_r),
    .io_claim_r(io_claim_r), .at_fwd_r(at_fwd_r), .rdata_r(rdata_r),
    .status_rd_r(status_rd_r), .legacy_rd_r(legacy_rd_r),
    .legacy_sel_r(legacy_sel_r), .unlocked_r(unlocked_r)
);
`default_nettype wire

//--- verif/rld_host_model.sv
// host processor model issuing i/o requests
`timescale 1ns/100ps
`default_nettype none
module rld_host_model (
    input  wire logic        clk,
    output var  logic [15:0] io_addr,
    output var  logic [15:0] io_wdata,
    output var  logic [1:0]  io_be,
    output var  logic        io_rd_stb,
    output var  logic        io_wr_stb
);
    initial begin
        io_addr   = 16'h0000;
        io_wdata  = 16'h0000;
        io_be     = 2'h0;
        io_rd_stb = 1'b0;
        io_wr_stb = 1'b0;
    end
    // one request, entered just after a rising edge
    task automatic cycle(input logic wr, input logic [15:0] a, input logic [15:0] d,
                         input logic [1:0] be);
        io_addr   = a;
        io_wdata  = d;
        io_be     = be;
        io_rd_stb = ~wr;
        io_wr_stb = wr;
        @(posedge clk);
        #1;
    endtask
    // released bus: strobes low, address and data scrambled
    task automatic idle;
        io_rd_stb = 1'b0;
        io_wr_stb = 1'b0;
        io_addr   = ~io_addr;
        io_wdata  = ~io_wdata;
        @(posedge clk);
        #1;
    endtask
    // eight-bit key write, junk in the upper byte
    task automatic write_key(input logic [7:0] k);
        cycle(1'b1, 16'hf073, {~k, k}, 2'h1);
    endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
// self-checking testbench for the register lock and i/o decode block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk;
    logic        rst;
    logic [3:0]  dma1_mask;
    logic [3:0]  dma2_mask;
    logic [7:0]  pport_ctl;
    wire  [15:0] io_addr;
    wire  [15:0] io_wdata;
    wire  [1:0]  io_be;
    wire         io_rd_stb;
    wire         io_wr_stb;
    wire         io_done_r;
    wire         io_claim_r;
    wire         at_fwd_r;
    wire  [15:0] rdata_r;
    wire         status_rd_r;
    wire         legacy_rd_r;
    wire         legacy_wr_r;
    wire         unlocked_r;
    wire         reg_rd_r;
    wire         reg_wr_r;
    wire  [5:0]  reg_idx_r;
    wire  [15:0] reg_wdata_r;
    wire  [1:0]  reg_be_r;
    rld_pkg::rld_legacy_type legacy_sel_r;
    int          err_total = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          seed;
    int          r;
    logic        exp_unl;
    logic        exp_tog;
    logic [9:0]  leg_lo [0:12] = '{10'h000, 10'h021, 10'h043, 10'h06e, 10'h061, 10'h070,
        10'h07f, 10'h080, 10'h092, 10'h0a1, 10'h0c0, 10'h0f0, 10'h0f1};
    logic [3:0]  leg_sel [0:12] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
        4'ha, 4'hb, 4'hc, 4'hd};
    rld_decode u_rld_decode (
        .clk(clk), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata), .io_be(io_be),
        .io_rd_stb(io_rd_stb), .io_wr_stb(io_wr_stb), .dma1_mask(dma1_mask),
        .dma2_mask(dma2_mask), .pport_ctl(pport_ctl), .io_done_r(io_done_r),
        .io_claim_r(io_claim_r), .at_fwd_r(at_fwd_r), .rdata_r(rdata_r),
        .status_rd_r(status_rd_r), .reg_rd_r(reg_rd_r), .reg_wr_r(reg_wr_r),
        .reg_idx_r(reg_idx_r), .reg_wdata_r(reg_wdata_r), .reg_be_r(reg_be_r),
        .legacy_rd_r(legacy_rd_r), .legacy_wr_r(legacy_wr_r),
        .legacy_sel_r(legacy_sel_r), .unlocked_r(unlocked_r)
    );
    rld_host_model u_rld_host_model (.clk(clk), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_be(io_be), .io_rd_stb(io_rd_stb), .io_wr_stb(io_wr_stb));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            end_of_test;
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    function automatic logic prot(input logic [15:0] a);
        return a[9:0] == 10'h072 && a[15:10] >= 6'h04
            && !(a[15:10] inside {6'h38, 6'h39, 6'h3a});
    endfunction
    // one request and its route
    task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d,
                       input logic [1:0] be);
        logic fwd;
        logic rg;
        fwd = (prot(a) && !exp_unl) || (!wr && a == 16'hf073);
        rg = !fwd && a[9:0] == 10'h072 && a[15:10] >= 6'h04 && a != 16'hfc72;
        u_rld_host_model.cycle(wr, a, d, be);
        check({11'h0, reg_rd_r, reg_wr_r, io_done_r, io_claim_r, at_fwd_r},
              {11'h0, rg & ~wr, rg & wr, 1'b1, ~fwd, fwd});
        if (rg) check({8'h0, reg_be_r, reg_idx_r}, {8'h0, be, a[15:10]});
        if (rg && wr) check(reg_wdata_r, d);
        if (!wr && a == 16'hfc72) exp_tog = ~exp_tog;
    endtask
    task automatic stat_rd;
        logic [15:0] e;
        r = $random(seed);
        {dma2_mask, dma1_mask, pport_ctl} = r[15:0];
        e = {exp_tog, 3'h0, dma2_mask, dma1_mask, pport_ctl[5], 3'h0};
        acc(1'b0, 16'hfc72, 16'h0000, 2'h3);
        check({15'h0, status_rd_r}, {15'h0, exp_unl});
        if (exp_unl) begin
            check(rdata_r, e);
        end
    endtask
    task automatic key(input logic [7:0] k);
        u_rld_host_model.write_key(k);
        exp_unl = (k == 8'hda);
        check({14'h0, io_claim_r, unlocked_r}, {14'h0, 1'b1, exp_unl});
    endtask
    initial begin
        seed = 23405;
        exp_unl = 1'b0;
        exp_tog = 1'b0;
        rst = 1'b1;
        dma1_mask = 4'h0;
        dma2_mask = 4'h0;
        pport_ctl = 8'h00;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        check({14'h0, unlocked_r, io_done_r}, 16'h0000);
        for (int i = 4; i < 64; i++) begin
            r = $random(seed);
            acc(r[0], {i[5:0], 10'h072}, r[31:16], 2'h3);
        end
        acc(1'b1, 16'hf073, 16'hda00, 2'h3);
        acc(1'b1, 16'hf073, 16'h00da, 2'h2);
        check({15'h0, unlocked_r}, 16'h0000);
        key(8'hda);
        acc(1'b0, 16'h1072, 16'h0000, 2'h3);
        repeat (2) stat_rd;
        acc(1'b1, 16'hfc72, 16'hffff, 2'h3);
        acc(1'b0, 16'hf073, 16'h0000, 2'h3);
        check({15'h0, unlocked_r}, 16'h0001);
        stat_rd;
        for (int i = 0; i < 13; i++) begin
            r = $random(seed);
            acc(r[0], {(i < 11) ? r[15:10] : 6'h00, leg_lo[i]}, r[31:16], 2'h3);
            check({10'h0, legacy_sel_r, legacy_rd_r, legacy_wr_r},
                  {10'h0, leg_sel[i], ~r[0], r[0]});
        end
        u_rld_host_model.cycle(1'b0, 16'h04f0, 16'h0000, 2'h3);
        check({15'h0, at_fwd_r}, 16'h0001);
        for (int i = 0; i < 300; i++) begin
            r = $random(seed);
            case (r[1:0])
                2'h0: key(r[2] ? 8'hda : r[15:8]);
                2'h1: stat_rd;
                default: acc(r[2], {r[8:3], 10'h072}, r[31:16], 2'h3);
            endcase
            if (r[9]) u_rld_host_model.idle;
        end
        key(8'hda);
        u_rld_host_model.idle;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        exp_unl = 1'b0;
        exp_tog = 1'b0;
        check({15'h0, unlocked_r}, 16'h0000);
        acc(1'b1, 16'h2072, 16'h1234, 2'h3);
        end_of_test;
    end
endmodule
`default_nettype wire
